// ===== src/tcps_pkg.sv
// Purpose: constants for the temperature conversion power scheduler
// Assumes: 25 MHz reference clock, register port with one-cycle read latency
// Notes:   register indices are byte offsets of a plain port
package tcps_pkg;
  localparam int CLK_HZ           = 25_000_000;
  localparam int PERIOD_US        = 400;
  localparam int POWERUP_US       = 4;
  localparam int CONV_US          = 40;
  localparam int PERIOD_CYC       = PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int POWERUP_CYC      = POWERUP_US * (CLK_HZ / 1_000_000);
  localparam int CONV_CYC         = CONV_US * (CLK_HZ / 1_000_000);

  localparam logic [2:0] ADDR_RESULT  = 3'h0;
  localparam logic [2:0] ADDR_CFG1    = 3'h1;
  localparam logic [2:0] ADDR_HYST    = 3'h2;
  localparam logic [2:0] ADDR_TRIP    = 3'h3;
  localparam logic [2:0] ADDR_CFG2    = 3'h4;
  localparam logic [2:0] ADDR_STATUS  = 3'h5;

  localparam logic [7:0] TRIP_RESET   = 8'h55;
  localparam logic [7:0] HYST_RESET   = 8'h4B;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [2:0] PTR_RESET    = ADDR_RESULT;

  localparam int SHUTDOWN_POS     = 0;
  localparam int BEHAVIOUR_POS    = 1;
  localparam int POLARITY_POS     = 2;
  localparam int FAULT_LO_POS     = 3;
  localparam int FAULT_HI_POS     = 4;
  localparam int PINMODE_POS      = 7;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_CONVERT = 4'b0010,
    ST_POWERUP = 4'b0100,
    ST_DOWN    = 4'b1000
  } tcps_state_t;
endpackage

// ===== src/tcps_alarm_if.sv
`timescale 1ns/1ps
// Purpose: carries conversion results from scheduler to alarm logic
// Assumes: single clock
// Notes:   none
interface tcps_alarm_if;
  logic       resultValid;
  logic [7:0] result;
  logic [7:0] tripLimit;
  logic [7:0] hystLimit;
  logic [7:0] cfg1;
  logic       readClear;
  logic       alarmActive;
  modport sched (output resultValid, output result, output tripLimit, output hystLimit,
                 output cfg1, output readClear, input alarmActive);
  modport alarm (input resultValid, input result, input tripLimit, input hystLimit,
                 input cfg1, input readClear, output alarmActive);
endinterface

// ===== src/tcps_alarm.sv
`timescale 1ns/1ps
// Purpose: fault queue and alarm behaviour
// Assumes: results arrive as one-cycle strobes
// Notes:   alarmActive is the logical level before polarity
module tcps_alarm
  import tcps_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  tcps_alarm_if.alarm al
);
  logic [2:0] faultCount;
  logic       alarm;
  logic       armedHot;

  wire        isHot    = al.result > al.tripLimit;
  wire        isCold   = al.result < al.hystLimit;
  wire        latched  = al.cfg1[BEHAVIOUR_POS];
  wire        shutdown = al.cfg1[SHUTDOWN_POS];
  wire [1:0]  faultSel = {al.cfg1[FAULT_HI_POS], al.cfg1[FAULT_LO_POS]};
  wire [2:0]  faultNeed = (faultSel == 2'h0) ? 3'h1 : (faultSel == 2'h1) ? 3'h2 :
                          (faultSel == 2'h2) ? 3'h4 : 3'h6;
  // fault is the excursion the alarm currently looks for
  wire        fault    = latched ? (armedHot ? isHot : isCold) : (alarm ? isCold : isHot);
  wire        queueHit = fault && (faultCount + 3'h1 >= faultNeed);

  assign al.alarmActive = alarm;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || shutdown) begin
      faultCount <= 3'h0;
      alarm      <= 1'b0;
      armedHot   <= 1'b1;
    end else begin
      if (al.resultValid) begin
        faultCount <= (fault && !queueHit) ? faultCount + 3'h1 : 3'h0;
      end
      if (latched) begin
        if (al.resultValid && queueHit) begin
          alarm    <= 1'b1;
          armedHot <= !armedHot;
        end else if (al.readClear) begin
          alarm <= 1'b0;
        end
      end else if (al.resultValid && queueHit) begin
        alarm <= !alarm;
      end
    end
  end

  shutdown_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(shutdown) |=> !alarm) else $error("alarm not cleared by shutdown");
  one_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (faultSel == 2'h0 && !latched && !alarm && !shutdown && al.resultValid && isHot) |=> alarm)
    else $error("single fault did not set alarm");
endmodule

// ===== src/tcps_scheduler.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Purpose: conversion scheduling and power-mode control
// Assumes: serial framing decoded outside; stopCond marks stop or repeated start
// Notes:   conversion result comes from an external converter via convDone
module tcps_scheduler
  import tcps_pkg::*;
#(
  parameter int PERIOD_CYCLES  = PERIOD_CYC,
  parameter int POWERUP_CYCLES = POWERUP_CYC
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic       stopCond,
  input  wire logic       convert_start_pin,
  input  wire logic       convDone,
  input  wire logic [7:0] convResult,
  input  wire logic       porLoaded,
  output logic            convStart,
  output logic            convAbort,
  output logic            trackHold,
  output logic            fullPowerDown,
  output logic            over_temp_alarm_out_o,
  output logic            over_temp_alarm_out_oe
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  result;
  logic [7:0]  tripLimit;
  logic [7:0]  hystLimit;
  logic [7:0]  cfg1;
  logic [7:0]  cfg2;
  logic [2:0]  pointer;
  logic        defaultsOk;
  logic        pendingStart;
  logic        wakeOnce;
  logic [1:0]  pinSync;
  logic        pinPrev;
  logic        pinHeldLong;
  logic [15:0] periodCnt;
  logic [15:0] powerupCnt;
  logic [15:0] convCnt;
  tcps_state_t state;
  tcps_state_t next_state;

  tcps_alarm_if al ();

  wire shutdown   = cfg1[SHUTDOWN_POS];
  wire pinMode    = cfg2[PINMODE_POS];
  wire pinLevel   = pinSync[1];
  wire pinRise    = pinLevel && !pinPrev;
  wire pinFall    = !pinLevel && pinPrev;
  wire resultRead = regRead && regAddr == ADDR_RESULT;
  wire periodDone = periodCnt == 16'(PERIOD_CYCLES - 1);
  wire powerupDone = powerupCnt == 16'(POWERUP_CYCLES - 1);
  wire converting = state == ST_CONVERT;
  wire convEnd    = converting && convDone;
  wire cfgWrite   = regWrite && regAddr == ADDR_CFG1;
  // start request under normal cadence
  wire periodicGo = defaultsOk && !shutdown && !pinMode && periodDone;
  wire pinGo      = (pinHeldLong && pinFall) || (powerupDone && !pinLevel);
  wire readGo     = pendingStart && stopCond;

  // ****************************************
  // conversion state machine
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (!defaultsOk) begin
          next_state = ST_IDLE;
        end else if (pinMode && pinRise) begin
          next_state = ST_POWERUP;
        end else if (!pinMode && (readGo || periodicGo || (shutdown && wakeOnce))) begin
          next_state = ST_CONVERT;
        end else if (shutdown) begin
          next_state = ST_DOWN;
        end
      end
      ST_POWERUP: begin
        if (pinGo) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (resultRead && !pinMode) begin
          next_state = ST_IDLE;
        end else if (convDone) begin
          next_state = (shutdown || (pinMode && !pinLevel)) ? ST_DOWN : ST_IDLE;
        end
      end
      ST_DOWN: begin
        if (pinMode && pinRise) begin
          next_state = ST_POWERUP;
        end else if (!pinMode && (wakeOnce || !shutdown)) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // start decision, so the cadence counts from the edge that launches convStart
  wire startNow = next_state == ST_CONVERT && state != ST_CONVERT;

  // ****************************************
  // timebase counters
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n || startNow || pinMode || shutdown) begin
      periodCnt <= 16'h0000;
    end else if (!periodDone) begin
      periodCnt <= periodCnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != ST_POWERUP) begin
      powerupCnt <= 16'h0000;
    end else if (!powerupDone) begin
      powerupCnt <= powerupCnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != ST_POWERUP) begin
      pinHeldLong <= 1'b0;
    end else if (powerupDone && pinLevel) begin
      pinHeldLong <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !converting) begin
      convCnt <= 16'h0000;
    end else begin
      convCnt <= convCnt + 16'h0001;
    end
  end

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinSync <= 2'b00;
      pinPrev <= 1'b0;
    end else begin
      pinSync <= {pinSync[0], convert_start_pin};
      pinPrev <= pinSync[1];
    end
  end

  // ****************************************
  // read and wake requests
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pendingStart <= 1'b0;
      wakeOnce     <= 1'b0;
    end else begin
      if (resultRead && !shutdown && !pinMode && defaultsOk) begin
        pendingStart <= 1'b1;
      end else if (readGo || state == ST_CONVERT) begin
        pendingStart <= 1'b0;
      end
      if (regWrite && shutdown && !pinMode && !(regAddr == ADDR_CFG1 && !regWdata[SHUTDOWN_POS])) begin
        wakeOnce <= 1'b1;
      end else if (convStart) begin
        wakeOnce <= 1'b0;
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pointer    <= PTR_RESET;
      tripLimit  <= TRIP_RESET;
      hystLimit  <= HYST_RESET;
      cfg1       <= CFG_RESET;
      cfg2       <= CFG_RESET;
      defaultsOk <= 1'b0;
      result     <= 8'h00;
    end else begin
      if (porLoaded) begin
        defaultsOk <= 1'b1;
      end else if (regWrite && regAddr == ADDR_TRIP) begin
        defaultsOk <= 1'b1;
      end
      if (regWrite) begin
        pointer <= regAddr;
      end
      if (regWrite && regAddr == ADDR_TRIP) begin
        tripLimit <= regWdata;
      end
      if (regWrite && regAddr == ADDR_HYST) begin
        hystLimit <= regWdata;
      end
      if (cfgWrite) begin
        cfg1 <= regWdata;
      end
      if (regWrite && regAddr == ADDR_CFG2) begin
        cfg2 <= regWdata;
      end
      if (convEnd && !(resultRead && !pinMode)) begin
        result <= convResult;
      end
    end
  end

  // read mux works in every power state
  wire [7:0] statusWord = {4'h0, state};
  wire [7:0] readMux    = (regAddr == ADDR_RESULT) ? result :
                          (regAddr == ADDR_CFG1)   ? cfg1 :
                          (regAddr == ADDR_HYST)   ? hystLimit :
                          (regAddr == ADDR_TRIP)   ? tripLimit :
                          (regAddr == ADDR_CFG2)   ? cfg2 :
                          (regAddr == ADDR_STATUS) ? statusWord : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRead ? readMux : 8'h00;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      convStart     <= 1'b0;
      convAbort     <= 1'b0;
      trackHold     <= 1'b0;
      fullPowerDown <= 1'b0;
    end else begin
      convStart     <= startNow;
      convAbort     <= converting && resultRead && !pinMode;
      trackHold     <= next_state == ST_CONVERT;
      fullPowerDown <= next_state == ST_DOWN;
    end
  end

  assign al.resultValid = convEnd && !(resultRead && !pinMode);
  assign al.result      = convResult;
  assign al.tripLimit   = tripLimit;
  assign al.hystLimit   = hystLimit;
  assign al.cfg1        = cfg1;
  assign al.readClear   = regRead;

  tcps_alarm u_alarm (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .al      (al)
  );

  // open drain: drive low when the pin should read low
  wire alarmLevel = al.alarmActive ^ !cfg1[POLARITY_POS];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      over_temp_alarm_out_o  <= 1'b0;
      over_temp_alarm_out_oe <= 1'b0;
    end else begin
      over_temp_alarm_out_o  <= 1'b0;
      over_temp_alarm_out_oe <= !alarmLevel;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  halted_in_shutdown_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (shutdown && !wakeOnce && !pinMode && state == ST_DOWN) |=> !convStart)
    else $error("conversion started in shutdown");
  no_start_unloaded_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !defaultsOk |-> !convStart) else $error("conversion without defaults");
  abort_on_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (converting && resultRead && !pinMode) |=> convAbort && state == ST_IDLE)
    else $error("read did not abort conversion");
  restart_at_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_IDLE && readGo && defaultsOk) |=> state == ST_CONVERT ##0 convStart)
    else $error("no restart at stop");
  powerup_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_IDLE && pinMode && pinRise && defaultsOk) |=> state == ST_POWERUP [*2])
    else $error("power-up interval too short");
  pin_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pinMode && state == ST_IDLE && !pinRise) |=> state != ST_CONVERT)
    else $error("conversion outside pin control");
  read_answers_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRead && regAddr == ADDR_TRIP) |=> regRdata == $past(tripLimit))
    else $error("register read wrong in any mode");
  periodic_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_IDLE && periodicGo) |=> state == ST_CONVERT)
    else $error("periodic conversion missed");
  cover_periodic: cover property (@(posedge ref_clk) state == ST_IDLE ##1 state == ST_CONVERT);
  cover_abort: cover property (@(posedge ref_clk) convAbort);
  cover_pin: cover property (@(posedge ref_clk) state == ST_POWERUP ##1 state == ST_CONVERT);
endmodule

// ===== verif/tcps_conv_model.sv
// Purpose: converter model facing the scheduler
// Assumes: one clock, convStart and convAbort are one-cycle pulses
// Notes:   result line shows the inverse of the last value outside convDone
`timescale 1ns/1ps
module tcps_conv_model #(
  parameter int CONV_N = 10
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       convStart,
  input  wire logic       convAbort,
  input  wire logic [7:0] tempVal,
  output logic            convDone,
  output logic      [7:0] convResult
);
  // ****************************************
  // conversion timing
  // ****************************************
  logic [7:0] cnt;
  logic       busy;
  logic [7:0] lastVal;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      cnt      <= 8'h00;
      convDone <= 1'b0;
      lastVal  <= 8'h00;
    end else begin
      convDone <= 1'b0;
      if (convAbort) begin
        busy <= 1'b0;
      end else if (convStart) begin
        busy <= 1'b1;
        cnt  <= 8'h00;
      end else if (busy) begin
        if (cnt == 8'(CONV_N - 1)) begin
          busy     <= 1'b0;
          convDone <= 1'b1;
          lastVal  <= tempVal;
        end
        cnt <= cnt + 8'h01;
      end
    end
  end
  // stale data must not look valid
  assign convResult = convDone ? lastVal : ~lastVal;
endmodule

// ===== verif/temp_conversion_power_scheduler_test.sv
// Purpose: self-checking bench for the conversion scheduler
// Assumes: shortened counts, converter model on the far side
// Notes:   reads of the result land idle, mid-conversion, in shutdown and in pin mode
`timescale 1ns/1ps
module temp_conversion_power_scheduler_test
  import tcps_pkg::*;
;
  localparam int PER   = 50;
  localparam int PUP   = 5;
  localparam int LIMIT = 20000;
  typedef struct {logic [2:0] a; logic [7:0] v;} tcps_row_t;
  tcps_row_t rows [8] = '{'{3'h0, 8'h00}, '{3'h1, 8'h00}, '{3'h2, 8'h4B}, '{3'h3, 8'h55},
                          '{3'h4, 8'h00}, '{3'h5, 8'h01}, '{3'h6, 8'h00}, '{3'h7, 8'h00}};
  logic       ref_clk, rst_n, regWrite, regRead, stopCond, convStartPin, porLoaded;
  logic       convDone, convStart, convAbort, trackHold, fullPowerDown, alarmO, alarmOe;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, convResult, tempVal, d;
  int         fails = 0, comparisons = 0, cyc = 0, starts = 0, aborts = 0;
  int         lastStart = 0, prevStart = 0, s0, rise;

  tcps_scheduler #(.PERIOD_CYCLES(PER), .POWERUP_CYCLES(PUP)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopCond(stopCond),
    .convert_start_pin(convStartPin), .convDone(convDone), .convResult(convResult),
    .porLoaded(porLoaded), .convStart(convStart), .convAbort(convAbort), .trackHold(trackHold),
    .fullPowerDown(fullPowerDown), .over_temp_alarm_out_o(alarmO), .over_temp_alarm_out_oe(alarmOe));
  tcps_conv_model #(.CONV_N(10)) conv_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .convStart(convStart), .convAbort(convAbort),
    .tempVal(tempVal), .convDone(convDone), .convResult(convResult));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // monitor, timeout and tasks
  // ****************************************
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (convStart === 1'b1) begin
      starts    <= starts + 1;
      prevStart <= lastStart;
      lastStart <= cyc;
    end
    if (convAbort === 1'b1) aborts <= aborts + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk) begin regAddr <= a; regWdata <= v; regWrite <= 1'b1; end
    @(posedge ref_clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk) begin regAddr <= a; regRead <= 1'b1; end
    @(posedge ref_clk) regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic pulseStop();
    @(posedge ref_clk) stopCond <= 1'b1;
    @(posedge ref_clk) stopCond <= 1'b0;
  endtask
  task automatic waitStart(input int lim);
    int n0;
    n0 = starts;
    for (int i = 0; i < lim && starts == n0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(starts != n0, 1);
  endtask
  task automatic waitDone(input int lim);
    for (int i = 0; i < lim && convDone !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(convDone, 1);
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n, regWrite, regRead, stopCond, convStartPin, porLoaded} = 6'h00;
    regAddr = 3'h0;
    regWdata = 8'h00;
    tempVal = 8'h30;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk(alarmOe, 0);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk(d, rows[i].v);
    end
    repeat (3 * PER) @(posedge ref_clk);
    chk(starts, 0);
    porLoaded <= 1'b1;
    waitStart(3 * PER);
    waitStart(PER + 5);
    chk(lastStart - prevStart, PER);
    waitDone(30);
    rd(3'h0, d);
    chk(d, 8'h30);
    tempVal <= 8'h31;
    waitStart(PER + 5);
    s0 = aborts;
    rd(3'h0, d);
    chk(d, 8'h30);
    repeat (3) @(posedge ref_clk);
    chk(aborts - s0, 1);
    pulseStop();
    waitStart(5);
    waitStart(PER + 5);
    chk(lastStart - prevStart, PER);
    waitDone(20);
    repeat (3) @(posedge ref_clk);
    rd(3'h0, d);
    chk(d, 8'h31);
    pulseStop();
    waitStart(5);
    waitStart(PER + 5);
    chk(lastStart - prevStart, PER);
    waitDone(20);
    wr(3'h1, 8'h10);
    tempVal <= 8'h60;
    for (int i = 1; i <= 4; i++) begin
      waitDone(PER + 20);
      repeat (3) @(posedge ref_clk);
      chk(alarmOe, i == 4);
    end
    wr(3'h1, 8'h11);
    repeat (2) @(posedge ref_clk);
    #1 chk(fullPowerDown, 1);
    chk(alarmOe, 0);
    s0 = starts;
    repeat (2 * PER) @(posedge ref_clk);
    chk(starts - s0, 0);
    tempVal <= 8'h42;
    wr(3'h3, 8'h55);
    repeat (3 * PER) @(posedge ref_clk);
    chk(starts - s0, 1);
    chk(fullPowerDown, 1);
    rd(3'h0, d);
    chk(d, 8'h42);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h80);
    repeat (20) @(posedge ref_clk);
    s0 = starts;
    rd(3'h0, d);
    pulseStop();
    repeat (2 * PER) @(posedge ref_clk);
    chk(starts - s0, 0);
    // pin pulses only while the register port is quiet
    @(posedge ref_clk) convStartPin <= 1'b1;
    #1 rise = cyc;
    repeat (2) @(posedge ref_clk);
    convStartPin <= 1'b0;
    waitStart(PUP + 12);
    chk(lastStart - rise >= PUP && lastStart - rise <= PUP + 6, 1);
    waitDone(30);
    repeat (3) @(posedge ref_clk);
    rd(3'h5, d);
    chk(d, 8'h08);
    @(posedge ref_clk) convStartPin <= 1'b1;
    s0 = starts;
    repeat (20) @(posedge ref_clk);
    chk(starts - s0, 0);
    convStartPin <= 1'b0;
    waitStart(8);
    waitDone(30);
    wr(3'h1, 8'h04);
    repeat (3) @(posedge ref_clk);
    #1 chk(alarmOe, 1);
    report_and_stop();
  end
endmodule
